//--- asmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module asmc_ctrl (
   input  wire logic                          core_clk,
   input  wire logic                          nrst,
   input  wire logic                          req_valid,
   output logic                               req_ready,
   input  wire logic                          req_write,
   input  wire logic [asmc_pkg::ADDR_W-1:0]   req_addr,
   input  wire logic [asmc_pkg::DATA_W-1:0]   req_wdata,
   input  wire logic                          req_oe_low,
   output logic                               rsp_valid,
   output logic [asmc_pkg::DATA_W-1:0]        rsp_rdata,
   input  wire logic                          retention_req,
   output logic                               retention_active,
   output logic [asmc_pkg::ADDR_W-1:0]        address_inputs,
   output logic                               select_n,
   output logic                               write_n,
   output logic                               out_drive_n,
   input  wire logic [asmc_pkg::DATA_W-1:0]   data_pins_i,
   output logic [asmc_pkg::DATA_W-1:0]        data_pins_o,
   output logic                               data_pins_oe
);
   // -------------------------------------------------------
   // state
   // -------------------------------------------------------
   typedef struct packed {
      asmc_pkg::asmc_state_t             st;
      logic [asmc_pkg::CNT_W-1:0]        cnt;
      logic                              wr;
      logic                              oe_low;
      logic [asmc_pkg::ADDR_W-1:0]       addr;
      logic [asmc_pkg::DATA_W-1:0]       wdata;
      logic [asmc_pkg::DATA_W-1:0]       rdata;
      logic                              rvalid;
      logic                              cs_n;
      logic                              we_n;
      logic                              oe_n;
      logic                              doe;
      logic [asmc_pkg::DATA_W-1:0]       sync1;
      logic [asmc_pkg::DATA_W-1:0]       sync2;
   } asmc_regs_t;

   // idle pins: every strobe released, host drivers off
   localparam asmc_regs_t S_RESET = '{
      st:     asmc_pkg::ASMC_IDLE,
      cnt:    asmc_pkg::CNT_ZERO,
      wr:     1'b0,
      oe_low: 1'b0,
      addr:   '0,
      wdata:  '0,
      rdata:  '0,
      rvalid: 1'b0,
      cs_n:   1'b1,
      we_n:   1'b1,
      oe_n:   1'b1,
      doe:    1'b0,
      sync1:  '0,
      sync2:  '0
   };

   asmc_regs_t s_r;
   asmc_regs_t s_nxt;

   function automatic logic [asmc_pkg::CNT_W-1:0] cnt_of(input int c);
      return asmc_pkg::CNT_W'(c - 1);
   endfunction

   // with output drive low the pulse also covers turn-off plus
   // overlap; it never drops below the plain minimum
   function automatic int wp_cyc(input logic oe_low);
      int c;
      c = asmc_pkg::WP_PLAIN_CYC;
      if (oe_low && asmc_pkg::WP_OE_CYC > c) begin
         c = asmc_pkg::WP_OE_CYC;
      end
      return c;
   endfunction

   // -------------------------------------------------------
   // sequencer
   // -------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;
      // read data passes two flops before use
      s_nxt.sync1 = data_pins_i;
      s_nxt.sync2 = s_r.sync1;
      // counter stops at zero; every state but IDLE and RET tests for zero
      if (s_r.cnt != asmc_pkg::CNT_ZERO) begin
         s_nxt.cnt = s_r.cnt - 4'h1;
      end
      case (s_r.st)
         asmc_pkg::ASMC_IDLE: begin
            s_nxt.cs_n = 1'b1;
            s_nxt.we_n = 1'b1;
            s_nxt.oe_n = 1'b1;
            s_nxt.doe = 1'b0;
            // retention wins over a pending request
            if (retention_req) begin
               s_nxt.st = asmc_pkg::ASMC_RET;
            end else if (req_valid) begin
               // address moves only with both strobes high
               s_nxt.addr = req_addr;
               s_nxt.wdata = req_wdata;
               s_nxt.wr = req_write;
               s_nxt.oe_low = req_oe_low;
               s_nxt.cnt = cnt_of(asmc_pkg::SETUP_CYC);
               s_nxt.st = asmc_pkg::ASMC_SETUP;
            end
         end
         asmc_pkg::ASMC_SETUP: begin
            if (s_r.cnt == asmc_pkg::CNT_ZERO) begin
               s_nxt.cs_n = 1'b0;
               if (s_r.wr) begin
                  // write falls with select; output drive goes low with it when oe_low is set
                  s_nxt.we_n = 1'b0;
                  s_nxt.oe_n = ~s_r.oe_low;
                  // pulse length follows the output drive level
                  s_nxt.cnt = cnt_of(wp_cyc(s_r.oe_low));
                  s_nxt.st = asmc_pkg::ASMC_WR;
               end else begin
                  s_nxt.oe_n = ~s_r.oe_low;
                  // select held through both sync flops on top of access
                  s_nxt.cnt = cnt_of(asmc_pkg::ACCESS_CYC
                                     + asmc_pkg::SYNC_CYC);
                  s_nxt.st = asmc_pkg::ASMC_RD;
               end
            end
         end
         asmc_pkg::ASMC_WR: begin
            // drive data only once memory drivers have turned off
            if (s_r.oe_n || s_r.cnt < cnt_of(asmc_pkg::WP_OE_CYC)) begin
               s_nxt.doe = 1'b1;
            end
            if (s_r.cnt == asmc_pkg::CNT_ZERO) begin
               // write strobe rises first; data held this edge
               s_nxt.we_n = 1'b1;
               // drive strobe off too: memory stays quiet while data holds
               s_nxt.oe_n = 1'b1;
               s_nxt.cnt = cnt_of(asmc_pkg::WC_CYC - wp_cyc(s_r.oe_low));
               s_nxt.st = asmc_pkg::ASMC_HOLD;
            end
         end
         asmc_pkg::ASMC_RD: begin
            if (s_r.cnt == asmc_pkg::CNT_ZERO) begin
               s_nxt.cs_n = 1'b1;
               s_nxt.oe_n = 1'b1;
               s_nxt.rdata = s_r.sync2;
               s_nxt.rvalid = 1'b1;
               s_nxt.cnt = cnt_of(asmc_pkg::RC_CYC - asmc_pkg::ACCESS_CYC
                                  + 1);
               s_nxt.st = asmc_pkg::ASMC_HOLD;
            end
         end
         asmc_pkg::ASMC_HOLD: begin
            // data released a cycle after the write strobe rose
            s_nxt.doe = 1'b0;
            s_nxt.cs_n = 1'b1;
            s_nxt.oe_n = 1'b1;
            if (s_r.cnt == asmc_pkg::CNT_ZERO) begin
               s_nxt.st = asmc_pkg::ASMC_IDLE;
            end
         end
         asmc_pkg::ASMC_RET: begin
            // select kept high: contents held with no clock or refresh
            s_nxt.cs_n = 1'b1;
            if (!retention_req) begin
               s_nxt.cnt = cnt_of(asmc_pkg::RECOVERY_CYC);
               s_nxt.st = asmc_pkg::ASMC_RECOV;
            end
         end
         asmc_pkg::ASMC_RECOV: begin
            if (s_r.cnt == asmc_pkg::CNT_ZERO) begin
               s_nxt.st = asmc_pkg::ASMC_IDLE;
            end
         end
         default: begin
            s_nxt.st = asmc_pkg::ASMC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= S_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // -------------------------------------------------------
   // outputs
   // -------------------------------------------------------
   // combinational ready: a request is taken in the first idle cycle
   assign req_ready = (s_r.st == asmc_pkg::ASMC_IDLE) && !retention_req;
   assign rsp_valid = s_r.rvalid;
   assign rsp_rdata = s_r.rdata;
   assign retention_active = (s_r.st == asmc_pkg::ASMC_RET);
   assign address_inputs = s_r.addr;
   assign select_n = s_r.cs_n;
   assign write_n = s_r.we_n;
   assign out_drive_n = s_r.oe_n;
   // pins come only from flops, so no glitch reaches the memory
   assign data_pins_o = s_r.wdata;
   assign data_pins_oe = s_r.doe;
endmodule // asmc_ctrl
`default_nettype wire

//--- asmc_pkg.sv
`default_nettype none
package asmc_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;
   localparam int BANK_W = 2;
   localparam int CLK_PERIOD_PS = 25000;
   // slowest speed grade figures, in picoseconds
   localparam int READ_CYCLE_TIME_PS = 120000;
   localparam int ADDR_ACCESS_PS = 120000;
   localparam int WRITE_PULSE_PS = 90000;
   localparam int WRITE_CYCLE_PS = 120000;
   localparam int TURN_OFF_PS = 40000;
   localparam int DATA_OVERLAP_TIME_PS = 45000;
   localparam int ADDR_SETUP_PS = 5000;
   localparam int DESELECT_TO_RETENTION_TIME_PS = 0;
   // least times round up, none below one cycle
   function automatic int cyc_min(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int SETUP_CYC = cyc_min(ADDR_SETUP_PS);
   localparam int ACCESS_CYC = cyc_min(ADDR_ACCESS_PS);
   localparam int RC_CYC = cyc_min(READ_CYCLE_TIME_PS);
   localparam int WP_OE_CYC = cyc_min(TURN_OFF_PS + DATA_OVERLAP_TIME_PS);
   localparam int WP_PLAIN_CYC = cyc_min(WRITE_PULSE_PS);
   localparam int WC_CYC = cyc_min(WRITE_CYCLE_PS);
   localparam int RECOVERY_CYC = RC_CYC;
   // read data passes two flops before the sequencer sees it
   localparam int SYNC_CYC = 2;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
   typedef enum logic [2:0] {
      ASMC_IDLE, ASMC_SETUP, ASMC_RD, ASMC_WR, ASMC_HOLD, ASMC_RET,
      ASMC_RECOV
   } asmc_state_t;
endpackage
`default_nettype wire

//--- asmc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module asmc_chk (
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        req_ready,
   input  wire logic        rsp_valid,
   input  wire logic        retention_req,
   input  wire logic        retention_active,
   input  wire logic [18:0] address_inputs,
   input  wire logic        select_n,
   input  wire logic        write_n,
   input  wire logic        out_drive_n,
   input  wire logic        data_pins_oe
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence s_rd_hold;
      (!select_n && write_n)[*7];
   endsequence
   sequence s_wr_pulse;
      (!write_n)[*4];
   endsequence
   AST_ADDR_CHG: assert property ($changed(address_inputs) |->
      (write_n && $past(write_n)) || (select_n && $past(select_n)))
      else $error("address moved under active strobes");
   AST_CONTENTION: assert property (data_pins_oe |->
      !(write_n && !out_drive_n && !select_n))
      else $error("host drives while memory drives");
   AST_WR_PULSE: assert property ($fell(write_n) |-> s_wr_pulse)
      else $error("write pulse too short");
   AST_WR_END: assert property ($rose(write_n) |->
      !select_n ##[1:2] select_n)
      else $error("write end order wrong");
   AST_SEL_WR: assert property ($fell(write_n) |-> $fell(select_n))
      else $error("select and write fell apart");
   AST_READ: assert property ($fell(select_n) && write_n |->
      s_rd_hold ##1 (select_n && rsp_valid))
      else $error("read walk wrong");
   AST_RET_DESEL: assert property (retention_active |->
      select_n && write_n)
      else $error("selected during retention");
   AST_RET_RECOV: assert property ($fell(retention_req) |->
      (!req_ready)[*5])
      else $error("access resumed too early");
endmodule // asmc_chk
bind asmc_ctrl asmc_chk u_chk (.core_clk, .nrst, .req_ready, .rsp_valid,
   .retention_req, .retention_active, .address_inputs, .select_n,
   .write_n, .out_drive_n, .data_pins_oe);
`default_nettype wire

//--- asmc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asmc_mem_model (
   input  wire logic [18:0] address_inputs,
   input  wire logic        select_n,
   input  wire logic        write_n,
   input  wire logic        out_drive_n,
   input  wire logic [7:0]  data_pins_o,
   input  wire logic        data_pins_oe,
   output var  logic [7:0]  bus
);
   logic [7:0] bank_mem [4][131072];
   logic [1:0] bank;
   int         ofs;
   logic       drv;
   assign bank = address_inputs[18:17];
   assign ofs = int'(address_inputs[16:0]);
   assign drv = !select_n && !out_drive_n && write_n;
   initial bus = 8'h00;
   // no pull-up: a released line never keeps its last level
   always @(select_n, write_n, out_drive_n, address_inputs, data_pins_o,
            data_pins_oe) begin
      if (data_pins_oe) bus = data_pins_o;
      else if (drv) bus = bank_mem[bank][ofs];
      else bus = ~bus;
      // whatever the pins carry is stored, garbage included
      if (!select_n && !write_n) bank_mem[bank][ofs] = bus;
   end
endmodule // asmc_mem_model
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        core_clk = 1'b0, nrst = 1'b0, req_valid = 1'b0;
   logic        req_write = 1'b0, req_oe_low = 1'b0, retention_req = 1'b0;
   logic [18:0] req_addr = 19'h0, address_inputs;
   logic [7:0]  req_wdata = 8'h00, rsp_rdata, data_pins_i, data_pins_o;
   logic        req_ready, rsp_valid, retention_active;
   logic        select_n, write_n, out_drive_n, data_pins_oe;
   int          n_mismatch = 0, check_count = 0;
   always #12.5 core_clk = ~core_clk;
   asmc_ctrl dut (.core_clk, .nrst, .req_valid, .req_ready, .req_write,
      .req_addr, .req_wdata, .req_oe_low, .rsp_valid, .rsp_rdata,
      .retention_req, .retention_active, .address_inputs, .select_n,
      .write_n, .out_drive_n, .data_pins_i, .data_pins_o, .data_pins_oe);
   asmc_mem_model u_mem (.address_inputs, .select_n, .write_n,
      .out_drive_n, .data_pins_o, .data_pins_oe, .bus(data_pins_i));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic access(input logic wr, input logic [18:0] a,
                         input logic [7:0] d, input logic oe);
      int i;
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= wr;
      req_addr <= a;
      req_wdata <= d;
      req_oe_low <= oe;
      i = 0;
      do @(negedge core_clk); while (!req_ready && ++i < 50);
      @(posedge core_clk);
      req_valid <= 1'b0;
      for (i = 0; i < 20 && !wr && rsp_valid !== 1'b1; i++)
         @(negedge core_clk);
      if (!wr) check({7'h0, rsp_valid}, 8'h01);
      if (!wr && oe) check(rsp_rdata, d);
   endtask
   task automatic t_banks;
      for (int b = 0; b < 4; b++) begin
         access(1'b1, {b[1:0], 17'h00000}, {b[1:0], 6'h2a}, b[0]);
         access(1'b1, {b[1:0], 17'h1ffff}, ~{b[1:0], 6'h2a}, ~b[0]);
      end
      for (int b = 0; b < 4; b++) begin
         access(1'b0, {b[1:0], 17'h00000}, {b[1:0], 6'h2a}, 1'b1);
         access(1'b0, {b[1:0], 17'h1ffff}, ~{b[1:0], 6'h2a}, 1'b1);
      end
      // active cycle without output drive: only the handshake is judged
      access(1'b0, 19'h00000, 8'h00, 1'b0);
   endtask
   task automatic t_ret;
      int i;
      access(1'b1, 19'h2abcd, 8'h5a, 1'b0);
      @(posedge core_clk);
      retention_req <= 1'b1;
      i = 0;
      do @(negedge core_clk); while (!retention_active && ++i < 20);
      repeat (3) @(negedge core_clk);
      check({5'h0, req_ready, retention_active, select_n}, 8'h03);
      @(posedge core_clk);
      retention_req <= 1'b0;
      i = 0;
      do @(negedge core_clk); while (!req_ready && ++i < 50);
      check({7'h0, req_ready}, 8'h01);
      check({7'h0, i > asmc_pkg::RC_CYC}, 8'h01);
      access(1'b0, 19'h2abcd, 8'h5a, 1'b1);
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      t_banks();
      t_ret();
      complete_run();
   end
   initial begin
      #200000;
      n_mismatch++;
      complete_run();
   end
endmodule // testbench
`default_nettype wire
